// ===== core/hall_period_speed_calc.sv
// hall period capture and fractional speed calculation
// assumes hall inputs and strobes are synchronous to mclk and debounced upstream
`timescale 1ns/100ps

// Functional notes
// - speed is computed from the revolution period unless the sector option selects the sector period.
// - a sector period is the tick count between two successive transitions on any hall input, six per revolution.
// - the revolution period runs from one transition to the same one a revolution later, refreshed on every transition.
// - speed equals the scaling constant divided by the revolution period (six sector periods when useSector is high), as a signed fraction of full speed.
// - the period is taken as electrical, pole pairs being folded into the scaling constant.
// - the speed calculation runs once every sixteenth pwm period.
// - hall transitions are captured at any moment, independent of pwm timing.
// - fractions are 24-bit signed with one sign bit and 23 fraction bits, the most negative code being minus one.
module hall_period_speed_calc
  import hps_pkg::*;
(
  input wire logic mclk, // module clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [2:0] hallIn, // hall-like sensor levels
  input wire logic timebaseTick, // one pulse per timebase tick
  input wire logic pwmPeriodStart, // one pulse at each pwm period start
  input wire logic useSector, // high selects the sector period
  input wire logic [FRAC_W-1:0] scaleConst, // scaling constant, unsigned ticks
  output logic [FRAC_W-1:0] speed, // signed fractional speed
  output logic speedValid, // pulse when speed is refreshed
  output logic [FRAC_W-1:0] sectorPeriod, // last sector period in ticks
  output logic [FRAC_W-1:0] revPeriod, // last revolution period in ticks
  output logic sectorValid, // a sector period has been measured
  output logic revValid // a revolution period has been measured
);
  typedef struct packed {
    logic primed;
    logic [2:0] hallPrev;
    logic [FRAC_W-1:0] timer;
    logic [SECTORS-1:0][FRAC_W-1:0] stamp;
    logic [FRAC_W-1:0] lastStamp;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] seen;
    logic [FRAC_W-1:0] sector;
    logic [FRAC_W-1:0] rev;
    logic revOk;
    logic [PWM_CNT_W-1:0] pwmCnt;
    logic calcReq;
    logic [FRAC_W-1:0] speed;
    logic speedValid;
  } hps_main_reg_t;

  hps_main_reg_t s;
  hps_main_reg_t next_s;
  hps_div_if div ();

  logic hallEdge;
  logic periodOk;
  logic [DIVR_W-1:0] periodSel;

  hps_div u_div (
    .mclk(mclk),
    .rst(rst),
    .div(div)
  );

  // transition on any input; the first sample after reset only primes the history
  assign hallEdge = s.primed && (hallIn != s.hallPrev);

  always_comb begin
    // sector scaled by six so both sources share one scaling constant
    if (useSector) begin
      periodSel = {1'b0, s.sector, 2'b00} + {2'b00, s.sector, 1'b0};
      periodOk = (s.seen >= 3'h2);
    end else begin
      periodSel = {3'b000, s.rev};
      periodOk = s.revOk;
    end
  end

  always_comb begin
    next_s = s;
    next_s.speedValid = 1'b0;
    next_s.primed = 1'b1;
    next_s.hallPrev = hallIn;
    div.start = 1'b0;
    div.dividend = scaleConst;
    div.divisor = periodSel;

    // free-running timebase; periods are modulo differences so wrap is harmless
    if (timebaseTick) begin
      next_s.timer = s.timer + TICK_ONE;
    end

    // capture runs every cycle, never gated by the pwm cadence
    if (hallEdge) begin
      if (s.seen != 3'h0) begin
        next_s.sector = s.timer - s.lastStamp;
      end
      if (s.seen == SEEN_FULL) begin
        next_s.rev = s.timer - s.stamp[s.widx];
        next_s.revOk = 1'b1;
      end
      next_s.stamp[s.widx] = s.timer;
      next_s.lastStamp = s.timer;
      if (s.widx == IDX_LAST) begin
        next_s.widx = '0;
      end else begin
        next_s.widx = s.widx + 3'h1;
      end
      if (s.seen != SEEN_FULL) begin
        next_s.seen = s.seen + 3'h1;
      end
    end

    // a pending request waits for the divider; the sixteen-period gap keeps it short
    // a quotient being delivered owns this cycle's update, so an immediate result would be lost
    if (s.calcReq && !div.busy && !div.done) begin
      next_s.calcReq = 1'b0;
      if (!periodOk) begin
        // no full period yet: report standstill rather than a stale figure
        next_s.speed = FRAC_ZERO;
        next_s.speedValid = 1'b1;
      end else if (periodSel == '0) begin
        next_s.speed = FRAC_MAX;
        next_s.speedValid = 1'b1;
      end else begin
        div.start = 1'b1;
      end
    end

    // set after clear so a new request is never lost
    if (pwmPeriodStart) begin
      next_s.pwmCnt = s.pwmCnt + 4'h1;
      if (s.pwmCnt == PWM_LAST) begin
        next_s.calcReq = 1'b1;
      end
    end

    if (div.done) begin
      // unsigned quotient above the positive range would read as negative
      if (div.quotient[FRAC_W-1]) begin
        next_s.speed = FRAC_MAX;
      end else begin
        next_s.speed = div.quotient;
      end
      next_s.speedValid = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign speed = s.speed;
  assign speedValid = s.speedValid;
  assign sectorPeriod = s.sector;
  assign revPeriod = s.rev;
  assign sectorValid = (s.seen >= 3'h2);
  assign revValid = s.revOk;
endmodule

// ===== shared/hps_pkg.sv
// constants, state types and widths for the hall period speed calculation
// assumes a single mclk domain and synchronous hall inputs
package hps_pkg;
  localparam int FRAC_W = 24;
  localparam int DIVR_W = 27;
  localparam int SECTORS = 6;
  localparam int IDX_W = 3;
  localparam int PWM_DECIM = 16;
  localparam int PWM_CNT_W = 4;
  localparam int STEP_W = 5;
  localparam logic [FRAC_W-1:0] FRAC_MAX = 24'h7FFFFF;
  localparam logic [FRAC_W-1:0] FRAC_MIN = 24'h800000;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 24'h000000;
  localparam logic [FRAC_W-1:0] TICK_ONE = 24'h000001;
  localparam logic [PWM_CNT_W-1:0] PWM_LAST = 4'hF;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;
  localparam logic [IDX_W-1:0] SEEN_FULL = 3'h6;
  localparam logic [STEP_W-1:0] DIV_LAST = 5'h17;
  typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} hps_div_state_t;
endpackage

// ===== shared/hps_div_if.sv
// divide request and answer between the speed calculation and its divider
// assumes both ends sit on the same mclk
`timescale 1ns/100ps
interface hps_div_if;
  import hps_pkg::*;
  logic start;
  logic [FRAC_W-1:0] dividend;
  logic [DIVR_W-1:0] divisor;
  logic busy;
  logic done;
  logic [FRAC_W-1:0] quotient;
  modport master (output start, output dividend, output divisor, input busy, input done, input quotient);
  modport slave (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface

// ===== core/hps_div.sv
// unsigned restoring divider, 24-bit dividend over 27-bit divisor
// assumes start is only raised while busy is low and the divisor is nonzero
`timescale 1ns/100ps
module hps_div
  import hps_pkg::*;
(
  input wire logic mclk, // module clock
  input wire logic rst, // synchronous reset, active high
  hps_div_if.slave div // divide request and answer
);
  typedef struct packed {
    hps_div_state_t state;
    logic [STEP_W-1:0] step;
    logic [DIVR_W:0] rem;
    logic [FRAC_W-1:0] dvd;
    logic [DIVR_W-1:0] dvs;
    logic [FRAC_W-1:0] quo;
    logic done;
  } hps_div_reg_t;

  hps_div_reg_t s;
  hps_div_reg_t next_s;

  always_comb begin
    logic [DIVR_W:0] trial;
    trial = {s.rem[DIVR_W-1:0], s.dvd[FRAC_W-1]};
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.state)
      DIV_IDLE: begin
        if (div.start) begin
          next_s.state = DIV_RUN;
          next_s.step = '0;
          next_s.rem = '0;
          next_s.dvd = div.dividend;
          next_s.dvs = div.divisor;
          next_s.quo = '0;
        end
      end
      DIV_RUN: begin
        next_s.dvd = {s.dvd[FRAC_W-2:0], 1'b0};
        if (trial >= {1'b0, s.dvs}) begin
          next_s.rem = trial - {1'b0, s.dvs};
          next_s.quo = {s.quo[FRAC_W-2:0], 1'b1};
        end else begin
          next_s.rem = trial;
          next_s.quo = {s.quo[FRAC_W-2:0], 1'b0};
        end
        if (s.step == DIV_LAST) begin
          next_s.state = DIV_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.step = s.step + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div.busy = (s.state == DIV_RUN);
  assign div.done = s.done;
  assign div.quotient = s.quo;
endmodule

// ===== test/hps_hall_sva.sv
// assertions on the speed calculation top ports
// assumes one mclk domain and a synchronous active-high reset
`timescale 1ns/100ps
module hps_hall_sva
  import hps_pkg::*;
(
  input wire logic mclk, // module clock
  input wire logic rst, // synchronous reset
  input wire logic [2:0] hallIn, // sensor levels
  input wire logic [FRAC_W-1:0] speed, // fractional speed
  input wire logic speedValid, // speed refresh pulse
  input wire logic [FRAC_W-1:0] sectorPeriod, // sector ticks
  input wire logic [FRAC_W-1:0] revPeriod, // revolution ticks
  input wire logic sectorValid, // sector measured
  input wire logic revValid // revolution measured
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_valid_gap: assert property (speedValid |=> !speedValid [*8]) else $error("speed refresh too close");
  a_sector_hold: assert property ($stable(hallIn) |=> $stable(sectorPeriod)) else $error("sector moved");
  a_rev_hold: assert property ($stable(hallIn) |=> $stable(revPeriod)) else $error("rev moved");
  a_speed_hold: assert property (!speedValid |-> $stable(speed)) else $error("speed moved");
  a_speed_sign: assert property (!speed[FRAC_W-1]) else $error("speed negative");
  a_sector_stays: assert property (sectorValid |=> sectorValid) else $error("sector flag lost");
  a_rev_stays: assert property (revValid |=> revValid) else $error("rev flag lost");
  a_rev_needs: assert property (revValid |-> sectorValid) else $error("rev before sector");
endmodule
bind hall_period_speed_calc hps_hall_sva hps_hall_sva_inst (.mclk(mclk), .rst(rst), .hallIn(hallIn),
  .speed(speed), .speedValid(speedValid), .sectorPeriod(sectorPeriod), .revPeriod(revPeriod),
  .sectorValid(sectorValid), .revValid(revValid));

// ===== test/hps_hall_model.sv
// hall-like sensor model stepping through six sector codes
// assumes step is a one-cycle pulse on mclk
`timescale 1ns/100ps
module hps_hall_model (
  input wire logic mclk, // module clock
  input wire logic rst, // synchronous reset
  input wire logic step, // advance one sector
  output logic [2:0] hallIn // sensor levels
);
  logic [2:0] idx;
  // one line flips per step, so every step is exactly one transition
  always_ff @(posedge mclk) begin
    if (rst) idx <= 3'h0;
    else if (step) idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
  end
  always_comb begin
    case (idx)
      3'h0: hallIn = 3'h1;
      3'h1: hallIn = 3'h3;
      3'h2: hallIn = 3'h2;
      3'h3: hallIn = 3'h6;
      3'h4: hallIn = 3'h4;
      default: hallIn = 3'h5;
    endcase
  end
endmodule

// ===== test/tb_top.sv
// bench: speed requests in both modes, interleaved with random hall gaps and ticks
// assumes the sensor model drives the hall lines
`timescale 1ns/100ps
module tb_top;
  import hps_pkg::*;
  logic mclk = 0, rst = 1, timebaseTick = 0, pwmPeriodStart = 0, useSector = 0, step = 0, pr = 0;
  logic speedValid, sectorValid, revValid;
  logic [2:0] hallIn, hp;
  logic [FRAC_W-1:0] scaleConst = 0, speed, sectorPeriod, revPeriod, tmr = 0, eSec = 0, eRev = 0;
  logic [FRAC_W-1:0] stamp [6];
  int mismatches = 0, n_compared = 0, cyc = 0, n = 0, seed = 32'h0C3F;
  always #2.5 mclk = ~mclk;
  hps_hall_model hps_hall_model_inst (.mclk, .rst, .step, .hallIn);
  hall_period_speed_calc hall_period_speed_calc_inst (.mclk, .rst, .hallIn, .timebaseTick, .pwmPeriodStart,
    .useSector, .scaleConst, .speed, .speedValid, .sectorPeriod, .revPeriod, .sectorValid, .revValid);
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [FRAC_W-1:0] seen, input logic [FRAC_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // floor of constant over period, standstill before a period exists, saturation at full scale
  function automatic logic [FRAC_W-1:0] exp_speed(input logic ok, input logic [DIVR_W-1:0] p,
    input logic [FRAC_W-1:0] sc);
    if (!ok) return FRAC_ZERO;
    if (p == '0) return FRAC_MAX;
    if ({3'h0, sc} / p >= 27'h800000) return FRAC_MAX;
    return 24'({3'h0, sc} / p);
  endfunction
  // ceiling far above the fewer than a thousand cycles the scenarios need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // own timer: the first sample after reset only primes the history
  always @(posedge mclk) begin
    hp <= hallIn;
    pr <= !rst;
    tmr <= rst ? FRAC_ZERO : tmr + {23'h0, timebaseTick};
    if (!rst && pr && hallIn !== hp) begin
      eSec <= tmr - stamp[0];
      eRev <= tmr - stamp[5];
      for (int i = 5; i > 0; i--) stamp[i] <= stamp[i - 1];
      stamp[0] <= tmr;
    end
  end
  task automatic hall(input int gap, input logic tk);
    repeat (gap) @(posedge mclk) timebaseTick <= tk & 1'($random(seed));
    @(posedge mclk) step <= 1;
    @(posedge mclk) step <= 0;
    repeat (2) @(posedge mclk);
    #1 n++;
    if (n >= 2) chk("sector", sectorPeriod, eSec);
    if (n >= 7) chk("rev", revPeriod, eRev);
    chk("flags", 24'({sectorValid, revValid}), 24'({n >= 2, n >= 7}));
    $display("hall test done");
  endtask
  task automatic spd(input logic us, input logic [FRAC_W-1:0] sc);
    logic [DIVR_W-1:0] p;
    logic [FRAC_W-1:0] e;
    logic ok, seen;
    int w;
    seen = 0;
    w = 0;
    ok = us ? n >= 2 : n >= 7;
    p = us ? {3'h0, eSec} * 27'h6 : {3'h0, eRev};
    e = exp_speed(ok, p, sc);
    @(posedge mclk) useSector <= us;
    scaleConst <= sc;
    for (int k = 0; k < 16; k++) begin
      repeat (2 + $unsigned($random(seed)) % 3) begin
        @(posedge mclk) pwmPeriodStart <= 0;
        #1 seen = seen | (speedValid === 1'b1);
      end
      @(posedge mclk) pwmPeriodStart <= 1;
    end
    @(posedge mclk) pwmPeriodStart <= 0;
    do begin
      @(posedge mclk);
      #1 w++;
    end while (speedValid !== 1'b1 && w < 40);
    chk("early", 24'(seen), FRAC_ZERO);
    chk("latency", 24'(w), (!ok || p == 0) ? 24'h1 : 24'h1A);
    chk("speed", speed, e);
    $display("speed test done");
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    spd(0, 24'h0FFFFF);
    repeat (3) hall(2, 0);
    spd(1, 24'h000100);
    for (int j = 0; j < 12; j++) hall(1 + $unsigned($random(seed)) % 8, 1);
    spd(0, 24'($random(seed)) & 24'h0FFFFF);
    spd(1, 24'($random(seed)) & 24'h0FFFFF);
    repeat (6) hall(1, 0);
    spd(0, 24'hFFFFFF);
    hall(1, 1);
    spd(0, 24'hFFFFFF);
    test_done();
  end
endmodule
